//--- logic/sgc_defs.svh
// Constants for the serial gain control port
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH

// ----------------------------------------------------------------
// Gain codes
// ----------------------------------------------------------------
`define SGC_CODE_W 6
`define SGC_CODE_RESET 6'h01
`define SGC_CODE_MIN 6'h01
`define SGC_CODE_MAX 6'h3c
`define SGC_HALF_DB_W 8
`define SGC_HALF_DB_BASE 8'hcd
`define SGC_HALF_DB_STEP 8'h02

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SGC_ADDR_W 4
`define SGC_OFS_GAIN 4'h0
`define SGC_OFS_STATUS 4'h4
`define SGC_OFS_LOADS 4'h8
`define SGC_OFS_SERIAL 4'hc

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define SGC_ST_POWERED 0
`define SGC_ST_TX 1
`define SGC_ST_OPEN 2
`define SGC_ST_CODE_LSB 8
`define SGC_ST_DB_LSB 16
`define SGC_LOADS_W 16
`define SGC_LOADS_RESET 16'h0000

// ----------------------------------------------------------------
// Pin synchroniser slots
// ----------------------------------------------------------------
`define SGC_PIN_N 3
`define SGC_PIN_WIN 0
`define SGC_PIN_SLEEP 1
`define SGC_PIN_TX 2

`endif

//--- logic/sgc_pkg.sv
// Types for the serial gain control port
package sgc_pkg;
  typedef logic [5:0] sgc_code_t;
  typedef logic signed [7:0] sgc_half_db_t;
  typedef enum logic [1:0] {
    SGC_REG_GAIN = 2'b00,
    SGC_REG_STATUS = 2'b01,
    SGC_REG_LOADS = 2'b11,
    SGC_REG_SERIAL = 2'b10
  } sgc_reg_t;
endpackage

//--- logic/sgc_port.sv
// Serial gain control port with Avalon-MM register access
//
// Implementation choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defs.svh"

// What this block does
// - Six-bit shift register, word sent MSB first
// - Shift data bit on serial clock rise
// - Keep six LSBs, drop upper bits
// - Codes one to sixty each distinct
// - Codes 61 to 63 give maximum gain
// - Code 1 -25.5 dB, 1 dB steps
// - Sleep low powers down, output high impedance
// - Transmit gate low disables forward transmission
// - Window rise applies word, stops shifting
// - Window fall holds gain, enables shifting
// - Power-up gain code one, host gates transmit
// - Sleep and gate independent of serial clock
module sgc_port
  import sgc_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_clk,
  input wire logic load_window_n,
  input wire logic serial_gain_in,
  input wire logic sleep_n,
  input wire logic tx_gate,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [5:0] gain_code,
  output logic signed [7:0] gain_half_db,
  output logic amp_powered,
  output logic out_hiz,
  output logic tx_enabled
);

  // ----------------------------------------------------------------
  // Address decoding
  // ----------------------------------------------------------------
  function automatic logic [2:0] reg_decode(input logic [3:0] addr);
    logic [2:0] r;
    r = 3'h4;
    unique case (addr)
      `SGC_OFS_GAIN: r = {1'b0, SGC_REG_GAIN};
      `SGC_OFS_STATUS: r = {1'b0, SGC_REG_STATUS};
      `SGC_OFS_LOADS: r = {1'b0, SGC_REG_LOADS};
      `SGC_OFS_SERIAL: r = {1'b0, SGC_REG_SERIAL};
      default: r = 3'h4;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Link domain shift register
  // ----------------------------------------------------------------
  sgc_code_t shift_word;

  always_ff @(posedge serial_clk or posedge rst) begin
    if (rst) begin
      shift_word <= `SGC_CODE_RESET;
    end else if (!load_window_n) begin
      shift_word <= {shift_word[4:0], serial_gain_in};
    end
  end

  // Only six bits exist, so upper bits of a longer word fall off the top

  a_shift_msb_first: assert property (
    @(posedge serial_clk) disable iff (rst)
    !load_window_n |=> shift_word == {$past(shift_word[4:0]), $past(serial_gain_in)})
    else $error("shift register did not take the data bit");

  a_closed_no_shift: assert property (
    @(posedge serial_clk) disable iff (rst)
    load_window_n |=> $stable(shift_word))
    else $error("shift register moved with window closed");

  a_last_six_kept: assert property (
    @(posedge serial_clk) disable iff (rst)
    (!load_window_n) [*6] |=> shift_word == {$past(serial_gain_in, 6), $past(serial_gain_in, 5),
      $past(serial_gain_in, 4), $past(serial_gain_in, 3), $past(serial_gain_in, 2),
      $past(serial_gain_in)})
    else $error("shift register does not hold the last six bits");

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] pin_sync;

  assign pin_raw[`SGC_PIN_WIN] = load_window_n;
  assign pin_raw[`SGC_PIN_SLEEP] = sleep_n;
  assign pin_raw[`SGC_PIN_TX] = tx_gate;

  genvar gi;
  generate
    for (gi = 0; gi < `SGC_PIN_N; gi++) begin : g_pin
      sgc_sync #(
        .reset_level(gi == `SGC_PIN_WIN)
      ) u_sync (
        .clock(clock),
        .rst(rst),
        .async_in(pin_raw[gi]),
        .sync_out(pin_sync[gi])
      );
    end
  endgenerate

  logic win_s;
  logic sleep_s;
  logic tx_s;
  logic win_prev;
  logic win_rise;

  assign win_s = pin_sync[`SGC_PIN_WIN];
  assign sleep_s = pin_sync[`SGC_PIN_SLEEP];
  assign tx_s = pin_sync[`SGC_PIN_TX];

  // Window synchroniser resets to its idle high level like the previous
  // level, so the release never looks like a window close
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      win_prev <= 1'b1;
    end else begin
      win_prev <= win_s;
    end
  end

  // Word is stable here: shifting stops once the window is high
  assign win_rise = win_s && !win_prev;

  // ----------------------------------------------------------------
  // Avalon-MM slave handshake
  // ----------------------------------------------------------------
  logic bus_ack;
  logic bus_req;
  logic [2:0] bus_sel;
  logic gain_wr;

  assign bus_req = avs_read || avs_write;
  assign bus_sel = reg_decode(avs_address);
  assign avs_waitrequest = bus_req && !bus_ack;
  assign gain_wr = avs_write && bus_ack && bus_sel == {1'b0, SGC_REG_GAIN} && avs_byteenable[0];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req && !bus_ack;
    end
  end

  // ----------------------------------------------------------------
  // Applied gain latch
  // ----------------------------------------------------------------
  sgc_code_t applied_raw;
  sgc_code_t serial_snap;
  logic [15:0] load_count;

  // Serial load wins over a bus write in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      applied_raw <= `SGC_CODE_RESET;
    end else if (win_rise) begin
      applied_raw <= shift_word;
    end else if (gain_wr) begin
      applied_raw <= avs_writedata[5:0];
    end
  end
  // While the window is open only a bus write changes the latch

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_snap <= `SGC_CODE_RESET;
    end else if (win_rise) begin
      serial_snap <= shift_word;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      load_count <= `SGC_LOADS_RESET;
    end else if (win_rise) begin
      load_count <= load_count + 16'h0001;
    end
  end

  a_load_on_close: assert property (
    @(posedge clock) disable iff (rst)
    win_rise |=> applied_raw == $past(shift_word))
    else $error("closing window did not apply the shifted word");

  a_snap_on_close: assert property (
    @(posedge clock) disable iff (rst)
    win_rise |=> serial_snap == $past(shift_word))
    else $error("closing window did not record the shifted word");

  a_count_on_close: assert property (
    @(posedge clock) disable iff (rst)
    win_rise |=> load_count == $past(load_count) + 16'h0001)
    else $error("closing window did not count the load");

  a_no_count_open: assert property (
    @(posedge clock) disable iff (rst)
    !win_rise |=> $stable(load_count))
    else $error("load counted without a window close");

  a_hold_while_open: assert property (
    @(posedge clock) disable iff (rst)
    (!win_s && !gain_wr) |=> $stable(applied_raw))
    else $error("gain changed while the window was open");

  a_power_up_code: assert property (
    @(posedge clock) disable iff (rst)
    $past(rst) |-> applied_raw == `SGC_CODE_RESET && gain_code == `SGC_CODE_RESET)
    else $error("gain after reset is not code one");

  // ----------------------------------------------------------------
  // Gain code mapping
  // ----------------------------------------------------------------
  sgc_code_t next_gain_code;
  sgc_half_db_t next_gain_half_db;

  always_comb begin
    next_gain_code = applied_raw;
    if (applied_raw > `SGC_CODE_MAX) begin
      next_gain_code = `SGC_CODE_MAX;
    end else if (applied_raw < `SGC_CODE_MIN) begin
      next_gain_code = `SGC_CODE_MIN;
    end
    // Half-dB units: -51 at code one, two per code step
    next_gain_half_db = sgc_half_db_t'(`SGC_HALF_DB_BASE
      + `SGC_HALF_DB_STEP * {2'b00, next_gain_code - `SGC_CODE_MIN});
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gain_code <= `SGC_CODE_RESET;
      gain_half_db <= `SGC_HALF_DB_BASE;
    end else begin
      gain_code <= next_gain_code;
      gain_half_db <= next_gain_half_db;
    end
  end

  a_code_passes: assert property (
    @(posedge clock) disable iff (rst)
    (applied_raw >= `SGC_CODE_MIN && applied_raw <= `SGC_CODE_MAX)
    |=> gain_code == $past(applied_raw))
    else $error("valid code not applied as is");

  a_clamp_high: assert property (
    @(posedge clock) disable iff (rst)
    applied_raw > `SGC_CODE_MAX |=> gain_code == `SGC_CODE_MAX)
    else $error("code above sixty not clamped");

  a_gain_db_map: assert property (
    @(posedge clock) disable iff (rst)
    gain_half_db == sgc_half_db_t'(`SGC_HALF_DB_BASE
      + `SGC_HALF_DB_STEP * {2'b00, gain_code - `SGC_CODE_MIN}))
    else $error("gain in dB does not match the code");

  // ----------------------------------------------------------------
  // Power and transmit control
  // ----------------------------------------------------------------
  // Driven from the system clock only, never from the serial clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      amp_powered <= 1'b0;
      out_hiz <= 1'b1;
    end else begin
      amp_powered <= sleep_s;
      out_hiz <= !sleep_s;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_enabled <= 1'b0;
    end else begin
      tx_enabled <= tx_s && sleep_s;
    end
  end

  a_sleep_hiz: assert property (
    @(posedge clock) disable iff (rst)
    !sleep_s |=> out_hiz && !amp_powered && !tx_enabled)
    else $error("sleep did not power down the output");

  a_wake_powers: assert property (
    @(posedge clock) disable iff (rst)
    sleep_s |=> amp_powered && !out_hiz)
    else $error("sleep high did not power the output");

  a_tx_gate_on: assert property (
    @(posedge clock) disable iff (rst)
    (tx_s && sleep_s) |=> tx_enabled)
    else $error("transmit gate high did not enable transmission");

  a_tx_gate_off: assert property (
    @(posedge clock) disable iff (rst)
    !tx_s |=> !tx_enabled)
    else $error("transmit gate low did not disable transmission");

  a_tx_needs_power: assert property (
    @(posedge clock) disable iff (rst)
    tx_enabled |-> amp_powered)
    else $error("transmission enabled while powered down");

  // ----------------------------------------------------------------
  // Register read data
  // ----------------------------------------------------------------
  logic [31:0] next_readdata;

  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (bus_sel)
      {1'b0, SGC_REG_GAIN}: next_readdata[5:0] = applied_raw;
      {1'b0, SGC_REG_STATUS}: begin
        next_readdata[`SGC_ST_POWERED] = amp_powered;
        next_readdata[`SGC_ST_TX] = tx_enabled;
        next_readdata[`SGC_ST_OPEN] = !win_s;
        next_readdata[`SGC_ST_CODE_LSB +: 6] = gain_code;
        next_readdata[`SGC_ST_DB_LSB +: 8] = gain_half_db;
      end
      {1'b0, SGC_REG_LOADS}: next_readdata[15:0] = load_count;
      {1'b0, SGC_REG_SERIAL}: next_readdata[5:0] = serial_snap;
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      avs_readdata <= next_readdata;
    end
  end

endmodule
`default_nettype wire

//--- logic/sgc_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module sgc_sync
  import sgc_pkg::*;
#(
  parameter logic reset_level = 1'b0
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  // ----------------------------------------------------------------
  // Stage flops
  // ----------------------------------------------------------------
  logic stage1;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= reset_level;
      sync_out <= reset_level;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule
`default_nettype wire

//--- tb/serial_gain_control_port_tb.sv
// Testbench for the serial gain control port
`timescale 1ns/1ps
`default_nettype none
`include "sgc_defs.svh"
module serial_gain_control_port_tb;
  logic clock, rst, sleep_n, tx_gate, avs_read, avs_write;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, amp_powered, out_hiz, tx_enabled;
  logic [5:0] gain_code, cur_raw;
  logic signed [7:0] gain_half_db;
  logic [7:0] w8;
  logic [15:0] loads;
  wire serial_clk, load_window_n, serial_gain_in;
  int fail_count = 0;
  int n_checks = 0;
  integer seed = 14090;
  string name_q[$];
  logic [31:0] exp_q[$];
  logic [16:0] pin_q[$];

  sgc_port sgc_port_inst (.clock(clock), .rst(rst), .serial_clk(serial_clk),
    .load_window_n(load_window_n), .serial_gain_in(serial_gain_in), .sleep_n(sleep_n),
    .tx_gate(tx_gate), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .gain_code(gain_code),
    .gain_half_db(gain_half_db), .amp_powered(amp_powered), .out_hiz(out_hiz),
    .tx_enabled(tx_enabled));
  sgc_host_model sgc_host_model_inst (.serial_clk(serial_clk),
    .load_window_n(load_window_n), .serial_gain_in(serial_gain_in));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // ----------------------------------------------------------------
  // Expectations and comparisons
  // ----------------------------------------------------------------
  function automatic logic [5:0] eff(input logic [5:0] r);
    if (r == 6'h00) return `SGC_CODE_MIN;
    if (r > `SGC_CODE_MAX) return `SGC_CODE_MAX;
    return r;
  endfunction
  function automatic logic [7:0] hdb(input logic [5:0] r);
    return `SGC_HALF_DB_BASE + {1'b0, eff(r) - 6'h01, 1'b0};
  endfunction
  function automatic logic [31:0] st_exp(input logic open);
    return {8'h00, hdb(cur_raw), 2'b00, eff(cur_raw), 5'h00, open, tx_gate & sleep_n, sleep_n};
  endfunction
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp_pins(input logic [16:0] e, input logic [16:0] s);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] pins expected %h seen %h", e, s);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      cmp32(name_q.pop_front(), exp_q.pop_front(), avs_readdata);
      cmp_pins(pin_q.pop_front(),
        {amp_powered, out_hiz, tx_enabled, gain_code, gain_half_db});
    end
  end
  // ----------------------------------------------------------------
  // Bus and load tasks
  // ----------------------------------------------------------------
  task automatic bus_wait();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    if (n >= 40) begin
      fail_count++;
      final_report();
    end
  endtask
  task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    bus_wait();
    avs_write <= 1'b0;
  endtask
  task automatic bus_read(input logic [3:0] a, input logic [31:0] e, input string nm);
    name_q.push_back(nm);
    exp_q.push_back(e);
    pin_q.push_back({sleep_n, ~sleep_n, tx_gate & sleep_n, eff(cur_raw), hdb(cur_raw)});
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait();
    avs_read <= 1'b0;
  endtask
  task automatic check_regs();
    bus_read(`SGC_OFS_GAIN, {26'h0, cur_raw}, "gain");
    bus_read(`SGC_OFS_STATUS, st_exp(1'b0), "status");
    bus_read(`SGC_OFS_LOADS, {16'h0, loads}, "loads");
  endtask
  task automatic do_load(input logic [7:0] w, input logic wide);
    fork
      if (wide) sgc_host_model_inst.load8(w);
      else sgc_host_model_inst.load6(w[5:0]);
      begin
        repeat (40) @(posedge clock);
        bus_read(`SGC_OFS_STATUS, st_exp(1'b1), "status_open");
      end
    join
    cur_raw = w[5:0];
    loads++;
    check_regs();
    bus_read(`SGC_OFS_SERIAL, {26'h0, w[5:0]}, "serial");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    sleep_n = 1'b1;
    tx_gate = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    cur_raw = `SGC_CODE_RESET;
    loads = `SGC_LOADS_RESET;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check_regs();
    bus_read(4'h2, 32'h0, "unmapped");
    for (int c = 0; c < 64; c++) begin
      bus_write(`SGC_OFS_GAIN, {26'($random(seed)), 6'(c)}, 4'h1);
      cur_raw = 6'(c);
      bus_read(`SGC_OFS_STATUS, st_exp(1'b0), "sweep");
    end
    bus_write(`SGC_OFS_GAIN, 32'h05, 4'he);
    bus_write(`SGC_OFS_STATUS, 32'hffffffff, 4'hf);
    check_regs();
    do_load(8'h01, 1'b0);
    @(posedge clock);
    tx_gate <= 1'b1;
    repeat (4) @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      w8 = 8'($random(seed));
      do_load(w8, i[0]);
    end
    do_load(8'h4b, 1'b1);
    do_load(8'h3d, 1'b0);
    sgc_host_model_inst.stray(6'h2a);
    repeat (4) @(posedge clock);
    check_regs();
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      sleep_n <= i[1];
      tx_gate <= i[0];
      repeat (4) @(posedge clock);
      bus_read(`SGC_OFS_STATUS, st_exp(1'b0), "pins");
    end
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cur_raw = `SGC_CODE_RESET;
    loads = `SGC_LOADS_RESET;
    repeat (4) @(posedge clock);
    check_regs();
    repeat (2) @(posedge clock);
    final_report();
  end
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
endmodule
`default_nettype wire

//--- tb/sgc_host_model.sv
// Host controller model driving the serial gain link
`timescale 1ns/1ps
`default_nettype none
module sgc_host_model (
  output logic serial_clk,
  output logic load_window_n,
  output logic serial_gain_in
);
  // ----------------------------------------------------------------
  // Idle levels, clock stands still outside frames except in the stray task
  // ----------------------------------------------------------------
  initial begin
    serial_clk = 1'b0;
    load_window_n = 1'b1;
    serial_gain_in = 1'b0;
  end
  task automatic put_bit(input logic b);
    serial_gain_in = b;
    #62.5 serial_clk = 1'b1;
    #62.5 serial_clk = 1'b0;
  endtask
  task automatic close_win();
    #30 load_window_n = 1'b1;
    #20 serial_gain_in = ~serial_gain_in;
    #40;
  endtask
  task automatic load6(input logic [5:0] w);
    load_window_n = 1'b0;
    #30;
    for (int i = 5; i >= 0; i--) put_bit(w[i]);
    close_win();
  endtask
  task automatic load8(input logic [7:0] w);
    load_window_n = 1'b0;
    #30;
    for (int i = 7; i >= 0; i--) put_bit(w[i]);
    close_win();
  endtask
  task automatic stray(input logic [5:0] w);
    for (int i = 5; i >= 0; i--) put_bit(w[i]);
  endtask
endmodule
`default_nettype wire
